// ==== rtl/wdt_defines.svh ====
// Offsets, field positions, reset values and timing counts of the watchdog and reset block
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
// Register offsets
`define WDT_CTRL_ADDR 4'h0
`define FLAGS_CTRL_ADDR 4'h1
`define STATUS_ADDR 4'h2
// Watchdog control fields
`define KEY_LSB 3
`define KEY_MSB 7
`define SEL_MSB 2
`define KEY_VALID_A 5'h0a
`define KEY_VALID_B 5'h15
`define WDT_CTRL_RESET 8'h53
// Flag/control register bits
`define BIT_SOFT_RST 0
`define BIT_SPARE 1
`define BIT_LV_RST 2
`define BIT_UNUSED 6
`define FLAGS_CTRL_RESET 8'h00
// Status register bits
`define BIT_TIMEOUT 0
// Timing
`define CLK_PERIOD_NS 4
`define POWER_ON_DELAY_MS 50
`define POWER_ON_DELAY_CYC ((`POWER_ON_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define KEY_DEBOUNCE_SUB 2
`define SUPPLY_FILTER_NS 1000
`define SUPPLY_FILTER_CYC ((`SUPPLY_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUB_DIV_DEFAULT 7813
`endif

// ==== rtl/wdt_pkg.sv ====
// Types shared by the watchdog and reset block
package wdt_pkg;
    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // Reset requests leaving the block
    typedef struct packed {
        logic full_reset;
        logic pc_sp_reset;
    } reset_out_t;
    // Power-on sequencer states
    typedef enum logic [1:0] {
        PWR_HOLD,
        PWR_RUN
    } pwr_state_t;
endpackage

// ==== rtl/sub_tick_gen.sv ====
// Divider that makes the slow sub clock tick as a one-cycle enable
`timescale 1ns/10ps
module sub_tick_gen #(
    parameter int DIV = 7813
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Tick out
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_next;

    // Wrap counter; tick marks the wrap
    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg >= 32'(DIV - 1)) begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule

// ==== rtl/hold_filter.sv ====
// Filter that passes a level only after it holds for a minimum count
`timescale 1ns/10ps
module hold_filter #(
    parameter int COUNT = 250
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw level and qualify enable
    input wire logic level_in,
    input wire logic enable,
    input wire logic step,
    // Filtered pulse
    output logic fire
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic fire_next;

    // Count steps while level holds; restart when it drops
    always_comb begin
        cnt_next = cnt_reg;
        fire_next = 1'b0;
        if (!level_in || !enable) begin
            cnt_next = 32'h0;
        end else if (step) begin
            if (cnt_reg >= 32'(COUNT)) begin
                fire_next = 1'b1;
                cnt_next = 32'h0;
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 32'h0;
            fire <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            fire <= fire_next;
        end
    end
endmodule

// ==== rtl/watchdog_and_reset_control.sv ====
// Watchdog timer, power-on delay, supply-drop reset and reset-cause flags
// Function
// - Counter overflow resets the device
// - Two key patterns enable the watchdog
// - Bad key resets after 2-3 slow ticks
// - Key powers up as first valid pattern
// - Normal timeout: full reset, timeout flag set
// - Sleep timeout: flag, reset PC and SP
// - Bad key, clear instr, halt clear counter
// - Code 111 gives largest division ratio
// - Wait power-on delay before first instruction
// - Power-on reset clears program counter
// - Power-on sets all port registers ones
// - Supply drop resets and sets flag
// - Short supply drops are ignored
// - Supply drop reset off in sleep
// - Low-voltage flag cleared only by software
// - Control bit 6 reads zero
// - Control bit 1 is plain storage
// - Select field picks overflow count
// - Soft-reset flag set by bad key
// - Counter runs from slow sub clock
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`include "wdt_defines.svh"
module watchdog_and_reset_control #(
    parameter int SUB_DIV = `SUB_DIV_DEFAULT,
    parameter int POR_CYCLES = `POWER_ON_DELAY_CYC,
    parameter int FILTER_CYCLES = `SUPPLY_FILTER_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // CPU events
    input wire logic clear_watchdog_instr,
    input wire logic halt_instr,
    input wire logic low_power_mode,
    // Supply detector
    input wire logic supply_drop_reset,
    // Reset outputs
    output logic cpu_run,
    output logic full_reset,
    output logic pc_sp_reset,
    output logic port_preset
);
    wdt_pkg::reg_req_t req;
    wdt_pkg::reset_out_t rst_next;
    wdt_pkg::pwr_state_t pwr_reg;
    wdt_pkg::pwr_state_t pwr_next;
    logic [7:0] wdt_ctrl_reg, wdt_ctrl_next;   // Key and select field
    logic [7:0] flags_reg, flags_next;         // Reset-cause and spare bits
    logic timeout_flag_reg, timeout_flag_next; // Status timeout flag
    logic [18:0] wdt_cnt_reg, wdt_cnt_next;    // Sub-clock watchdog count
    logic [1:0] key_dly_reg, key_dly_next;     // Bad-key debounce count
    logic [31:0] por_cnt_reg, por_cnt_next;    // Power-on delay count
    logic [7:0] rdata_next;
    logic cpu_run_next, port_preset_next;
    logic sub_tick;
    logic lv_fire;
    logic key_ok;
    logic [4:0] key;
    logic [18:0] limit;
    logic wdt_clear;
    logic overflow;

    assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
    assign key = wdt_ctrl_reg[`KEY_MSB:`KEY_LSB];
    assign key_ok = (key == `KEY_VALID_A) || (key == `KEY_VALID_B);

    // Slow sub clock as an enable pulse
    sub_tick_gen #(.DIV(SUB_DIV)) u_tick (
        .clk(sys_clk),
        .srst(srst),
        .tick(sub_tick)
    );

    // Supply-drop filter, gated off in low-power modes
    hold_filter #(.COUNT(FILTER_CYCLES)) u_lvf (
        .clk(sys_clk),
        .srst(srst),
        .level_in(supply_drop_reset),
        .enable(!low_power_mode),
        .step(1'b1),
        .fire(lv_fire)
    );

    // Overflow limit from select code
    always_comb begin
        unique case (wdt_ctrl_reg[`SEL_MSB:0])
            3'h0: limit = 19'h00100;
            3'h1: limit = 19'h00400;
            3'h2: limit = 19'h01000;
            3'h3: limit = 19'h04000;
            3'h4: limit = 19'h08000;
            3'h5: limit = 19'h10000;
            3'h6: limit = 19'h20000;
            3'h7: limit = 19'h40000;
        endcase
    end

    // Clear sources; a bad key also clears the count
    assign wdt_clear = clear_watchdog_instr || halt_instr || !key_ok;
    assign overflow = key_ok && sub_tick && (wdt_cnt_reg >= limit - 19'h1);

    // Power-on sequencer: hold the CPU, then release
    always_comb begin
        pwr_next = pwr_reg;
        por_cnt_next = por_cnt_reg;
        cpu_run_next = 1'b0;
        port_preset_next = 1'b0;
        unique case (pwr_reg)
            wdt_pkg::PWR_HOLD: begin
                port_preset_next = 1'b1;
                if (por_cnt_reg >= 32'(POR_CYCLES - 1)) begin
                    pwr_next = wdt_pkg::PWR_RUN;
                    cpu_run_next = 1'b1;
                    port_preset_next = 1'b0;
                end else begin
                    por_cnt_next = por_cnt_reg + 32'h1;
                end
            end
            wdt_pkg::PWR_RUN: begin
                cpu_run_next = 1'b1;
            end
        endcase
    end

    // Counter, flags and resets
    always_comb begin
        wdt_ctrl_next = wdt_ctrl_reg;
        flags_next = flags_reg;
        timeout_flag_next = timeout_flag_reg;
        wdt_cnt_next = wdt_cnt_reg;
        key_dly_next = key_dly_reg;
        rst_next = '0;
        rdata_next = 8'h00;
        // Software writes
        if (req.wr && req.addr == `WDT_CTRL_ADDR) begin
            wdt_ctrl_next = req.wdata;
        end
        if (req.wr && req.addr == `FLAGS_CTRL_ADDR) begin
            flags_next = req.wdata;
        end
        if (req.wr && req.addr == `STATUS_ADDR) begin
            timeout_flag_next = req.wdata[`BIT_TIMEOUT];
        end
        flags_next[`BIT_UNUSED] = 1'b0;
        // Watchdog count
        if (wdt_clear) begin
            wdt_cnt_next = 19'h0;
        end else if (overflow) begin
            wdt_cnt_next = 19'h0;
        end else if (key_ok && sub_tick) begin
            wdt_cnt_next = wdt_cnt_reg + 19'h1;
        end
        // Timeout: full reset when running, PC/SP only in low power
        if (overflow && !wdt_clear) begin
            timeout_flag_next = 1'b1;
            if (low_power_mode) begin
                rst_next.pc_sp_reset = 1'b1;
            end else begin
                rst_next.full_reset = 1'b1;
            end
        end
        // Bad-key debounce over slow ticks
        if (key_ok) begin
            key_dly_next = 2'h0;
        end else if (sub_tick) begin
            if (key_dly_reg >= 2'(`KEY_DEBOUNCE_SUB)) begin
                rst_next.full_reset = 1'b1;
                flags_next[`BIT_SOFT_RST] = 1'b1;
                wdt_ctrl_next = `WDT_CTRL_RESET;
                key_dly_next = 2'h0;
            end else begin
                key_dly_next = key_dly_reg + 2'h1;
            end
        end
        // Supply drop; set wins over software clear
        if (lv_fire) begin
            rst_next.full_reset = 1'b1;
            flags_next[`BIT_LV_RST] = 1'b1;
        end
        // Read mux
        if (req.rd) begin
            unique case (req.addr)
                `WDT_CTRL_ADDR: rdata_next = wdt_ctrl_reg;
                `FLAGS_CTRL_ADDR: rdata_next = flags_reg & ~(8'h01 << `BIT_UNUSED);
                `STATUS_ADDR: rdata_next = {7'h00, timeout_flag_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register everything
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwr_reg <= wdt_pkg::PWR_HOLD;
            por_cnt_reg <= 32'h0;
            wdt_ctrl_reg <= `WDT_CTRL_RESET;
            flags_reg <= `FLAGS_CTRL_RESET;
            timeout_flag_reg <= 1'b0;
            wdt_cnt_reg <= 19'h0;
            key_dly_reg <= 2'h0;
            rdata <= 8'h00;
            cpu_run <= 1'b0;
            port_preset <= 1'b1;
            full_reset <= 1'b1;
            pc_sp_reset <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            por_cnt_reg <= por_cnt_next;
            wdt_ctrl_reg <= wdt_ctrl_next;
            flags_reg <= flags_next;
            timeout_flag_reg <= timeout_flag_next;
            wdt_cnt_reg <= wdt_cnt_next;
            key_dly_reg <= key_dly_next;
            rdata <= rdata_next;
            cpu_run <= cpu_run_next;
            port_preset <= port_preset_next;
            full_reset <= rst_next.full_reset || !cpu_run_next;
            pc_sp_reset <= rst_next.pc_sp_reset;
        end
    end
endmodule

// ==== tb/wdt_checker_sva.sv ====
// Port-level checks of the watchdog and reset block
`timescale 1ns/10ps
module wdt_checker_sva #(
    parameter int SUB_DIV = 4,
    parameter int POR_CYCLES = 10,
    parameter int FILTER_CYCLES = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    // CPU events and supply
    input wire logic clear_watchdog_instr,
    input wire logic halt_instr,
    input wire logic low_power_mode,
    input wire logic supply_drop_reset,
    // Reset outputs
    input wire logic cpu_run,
    input wire logic full_reset,
    input wire logic pc_sp_reset,
    input wire logic port_preset
);
    // Bound on the bad-key debounce, four sub ticks plus latency
    localparam int KEY_MAX = 4 * SUB_DIV + 4;
    // Cycles since reset release, since a count clear, of a held drop
    int por_reg, por_next, clr_reg, clr_next, drop_reg, drop_next;
    // Next values of the helper counters
    always_comb begin
        por_next = srst ? 0 : por_reg + 1;
        // Only a bad key write clears the count; a valid key write leaves it running
        clr_next = (srst || clear_watchdog_instr || halt_instr || pc_sp_reset ||
            (wr_stb && addr == 4'h0 && wdata[7:3] != 5'h0a && wdata[7:3] != 5'h15)) ? 0 : clr_reg + 1;
        drop_next = (srst || !supply_drop_reset || low_power_mode) ? 0 : drop_reg + 1;
    end
    // Register the helper counters
    always_ff @(posedge sys_clk) begin
        por_reg <= por_next;
        clr_reg <= clr_next;
        drop_reg <= drop_next;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Write of a key that is neither valid pattern
    sequence bad_key_s;
        wr_stb && addr == 4'h0 && wdata[7:3] != 5'h0a && wdata[7:3] != 5'h15 && cpu_run && !full_reset;
    endsequence
    // Debounce gap, then the reset pulse
    sequence key_wait_s;
        !full_reset [*2] ##[1:KEY_MAX] full_reset;
    endsequence
    unused_bit_a: assert property (rd_stb && addr == 4'h1 |=> rdata[6] == 1'b0)
        else $error("unused control bit read as one");
    idle_rdata_a: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    preset_hold_a: assert property (port_preset |-> !cpu_run)
        else $error("ports preset while running");
    por_delay_a: assert property ($rose(cpu_run) |-> por_reg >= POR_CYCLES - 1)
        else $error("run started before power-on delay");
    key_reset_a: assert property (bad_key_s |=> key_wait_s)
        else $error("bad key reset timing wrong");
    clear_hold_a: assert property (pc_sp_reset |-> clr_reg > 255 * SUB_DIV)
        else $error("timeout too soon after clear");
    drop_reset_a: assert property (drop_reg == FILTER_CYCLES + 1 |-> ##[0:4] full_reset)
        else $error("held supply drop gave no reset");
    sleep_timeout_a: assert property (pc_sp_reset |-> $past(low_power_mode) && !full_reset)
        else $error("partial reset outside low power");
endmodule

bind watchdog_and_reset_control wdt_checker_sva #(.SUB_DIV(SUB_DIV), .POR_CYCLES(POR_CYCLES),
    .FILTER_CYCLES(FILTER_CYCLES)) i_chk (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .clear_watchdog_instr(clear_watchdog_instr),
    .halt_instr(halt_instr), .low_power_mode(low_power_mode), .supply_drop_reset(supply_drop_reset),
    .cpu_run(cpu_run), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset), .port_preset(port_preset));

// ==== tb/tb_watchdog_and_reset_control.sv ====
// Testbench for the watchdog and reset block
`timescale 1ns/10ps
module tb_watchdog_and_reset_control;
    // Clock, reset and register bus
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    // CPU events, mode and supply level
    logic clr_i = 1'b0;
    logic halt_i = 1'b0;
    logic lp = 1'b0;
    logic drop = 1'b0;
    // Design outputs, and the reset kind seen by watch
    logic [7:0] rdata;
    logic cpu_run, full_reset, pc_sp_reset, port_preset, k;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    // Short counts keep the run brief
    watchdog_and_reset_control #(.SUB_DIV(4), .POR_CYCLES(10), .FILTER_CYCLES(5)) i_dut (.sys_clk(sys_clk),
        .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .clear_watchdog_instr(clr_i), .halt_instr(halt_i), .low_power_mode(lp), .supply_drop_reset(drop),
        .cpu_run(cpu_run), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset), .port_preset(port_preset));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    // Read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    // One-cycle clear (h=0) or halt (h=1)
    task automatic pulse(input logic h);
        @(posedge sys_clk);
        clr_i <= !h;
        halt_i <= h;
        @(posedge sys_clk);
        clr_i <= 1'b0;
        halt_i <= 1'b0;
    endtask
    // Cycles until a reset pulse (lim if none), then wait for the device to run again
    task automatic watch(input int lim, output int cnt, output logic kind);
        // Step off the edge so outputs are settled before the first look
        #1;
        for (cnt = 0; cnt < lim && full_reset !== 1'b1 && pc_sp_reset !== 1'b1; cnt++) begin
            @(posedge sys_clk);
            #1;
        end
        kind = pc_sp_reset;
        for (int i = 0; i < 40 && (full_reset !== 1'b0 || cpu_run !== 1'b1); i++) begin
            @(posedge sys_clk);
            #1;
        end
        // Device never came back: count it and stop
        if (full_reset !== 1'b0 || cpu_run !== 1'b1) begin
            error_cnt++;
            $display("Error cpu_run expected 1 seen %b", cpu_run);
            results();
        end
    endtask
    // Arm a timeout, clear the count and time the reset; a missing reset ends the run
    task automatic tmo(input logic [7:0] ctl, input int ticks, input logic low);
        wr(4'h0, ctl);
        pulse(1'b0);
        watch(ticks * 4 + 12, n, k);
        if (n == ticks * 4 + 12) begin
            error_cnt++;
            $display("Error period expected %0d seen %0d", ticks * 4, n);
            results();
        end
        chk("period", 1, n >= ticks * 4 - 8);
        chk("period max", 1, n <= ticks * 4 + 4);
        chk("reset kind", low, k);
        rd(4'h2, 8'h01);
        wr(4'h2, 8'h00);
    endtask
    // Main sequence
    initial begin
        repeat (7) @(posedge sys_clk);
        #1;
        chk("port_preset", 1, port_preset);
        chk("full_reset", 1, full_reset);
        @(posedge sys_clk);
        srst <= 1'b0;
        watch(0, n, k);
        chk("cpu_run", 1, cpu_run);
        chk("port_preset", 0, port_preset);
        rd(4'h0, 8'h53);
        rd(4'h1, 8'h00);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'hbf);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h9, 8'h00);
        wr(4'h0, 8'h50);
        // Clears and halts keep a short timeout from firing
        for (int i = 0; i < 4; i++) begin
            pulse(i[0]);
            watch(900, n, k);
            chk("no timeout", 900, n);
        end
        tmo(8'h50, 256, 1'b0);
        tmo(8'ha9, 1024, 1'b0);
        lp <= 1'b1;
        tmo(8'h50, 256, 1'b1);
        pulse(1'b0);
        drop <= 1'b1;
        watch(30, n, k);
        chk("sleep drop", 30, n);
        @(posedge sys_clk);
        drop <= 1'b0;
        lp <= 1'b0;
        // Drop shorter than the filter
        repeat (3) @(posedge sys_clk);
        drop <= 1'b1;
        repeat (3) @(posedge sys_clk);
        drop <= 1'b0;
        watch(30, n, k);
        chk("short drop", 30, n);
        rd(4'h1, 8'h00);
        // Drop longer than the filter; watch while it is held so the one-cycle pulse is seen
        @(posedge sys_clk);
        drop <= 1'b1;
        watch(30, n, k);
        chk("drop reset", 1, n > 5 && n < 30);
        @(posedge sys_clk);
        drop <= 1'b0;
        rd(4'h1, 8'h04);
        wr(4'h0, 8'h03);
        watch(30, n, k);
        chk("key reset", 1, n < 30);
        chk("key delay", 1, n >= 8 && n <= 14);
        rd(4'h1, 8'h05);
        rd(4'h0, 8'h53);
        results();
    end
endmodule
